//--- vfd_cfg.svh
// constants for the vliw fetch and dispatch core
// assumes a single 100 MHz clock and synchronous active-high reset
`ifndef VFD_CFG_SVH
`define VFD_CFG_SVH
`define VFD_FETCH_BITS 256
`define VFD_INSN_BITS 32
`define VFD_SLOTS 8
`define VFD_REGS 32
`define VFD_CHAIN_BIT 0
`define VFD_SIDE_BIT 1
`define VFD_UNIT_LSB 2
`define VFD_XPATH_BIT 4
`define VFD_DST_LSB 5
`define VFD_SRC_LSB 10
`define VFD_RESET_PC 32'h00000000
`endif

//--- vfd_pkg.sv
// types for the vliw fetch and dispatch core
// assumes vfd_cfg.svh is on the include path
package vfd_pkg;
  typedef enum logic [1:0] {
    VFD_IDLE = 2'b00,
    VFD_WAIT = 2'b01,
    VFD_RUN = 2'b10
  } vfd_state_type;
  // unit index: bit 2 selects side b
  typedef enum logic [2:0] {
    VFD_A_LOGIC = 3'b000,
    VFD_A_SHIFT = 3'b001,
    VFD_A_MUL = 3'b010,
    VFD_A_DATA = 3'b011,
    VFD_B_LOGIC = 3'b100,
    VFD_B_SHIFT = 3'b101,
    VFD_B_MUL = 3'b110,
    VFD_B_DATA = 3'b111
  } vfd_unit_type;
endpackage : vfd_pkg

//--- vfd_dispatch.sv
// fetch packet sequencer, execute packet former and unit dispatcher
// assumes program memory answers a fetch request with one valid pulse
`timescale 1ns/100ps
`include "vfd_cfg.svh"
module vfd_dispatch
  import vfd_pkg::*;
#(
  parameter int SLOTS = `VFD_SLOTS,
  parameter int IW = `VFD_INSN_BITS
) (
  input wire logic clk, // core clock
  input wire logic srst, // sync reset
  output logic fetch_req, // fetch request pulse
  output logic [31:0] fetch_addr, // fetch packet byte address
  input wire logic fetch_valid, // fetch packet returned
  input wire logic [SLOTS*IW-1:0] fetch_data, // eight instructions, slot 0 low
  output logic [SLOTS-1:0] unit_valid, // per unit issue strobe
  output logic [SLOTS*IW-1:0] unit_insn, // per unit instruction
  output logic packet_issue, // one execute packet issued
  output logic xpath_stall // cross-path delay clock
);
  localparam int PW = $clog2(SLOTS);

  typedef struct packed {
    vfd_state_type st;
    logic [31:0] pc;
    logic [SLOTS*IW-1:0] fp;
    logic [PW:0] pos;
    logic [SLOTS*IW-1:0] carry;
    logic [SLOTS-1:0] carry_v;
    logic carry_open;
    logic [SLOTS-1:0] uv;
    logic [SLOTS*IW-1:0] ui;
    logic issue;
    logic stall;
    logic [2*`VFD_REGS-1:0] wr_last;
    logic req;
  } vfd_state_s_type;

  vfd_state_s_type s_q, s_d;

  ////////////////////////////////////////////////////////////////////////////
  logic [IW-1:0] insn [SLOTS];
  logic [PW:0] end_pos;
  logic found_end;
  logic [SLOTS-1:0] take;
  logic hazard;
  logic [SLOTS-1:0] pv;
  logic [SLOTS*IW-1:0] pi;
  logic [2*`VFD_REGS-1:0] wr_now;
  logic [2:0] u;
  logic [5:0] ridx;

  always_comb begin
    for (int i = 0; i < SLOTS; i++) begin
      insn[i] = s_q.fp[i*IW +: IW];
    end
    // scan chain bits from current slot to the packet end
    found_end = 1'b0;
    end_pos = (PW+1)'(SLOTS);
    take = '0;
    u = 3'h0;
    ridx = 6'h00;
    for (int i = 0; i < SLOTS; i++) begin
      if (i >= s_q.pos && !found_end) begin
        take[i] = 1'b1;
        if (!insn[i][`VFD_CHAIN_BIT]) begin
          found_end = 1'b1;
          end_pos = (PW+1)'(i + 1);
        end
      end
    end
    // merge carried slots from previous fetch packet with this one
    pv = '0;
    pi = '0;
    wr_now = '0;
    hazard = 1'b0;
    for (int i = 0; i < SLOTS; i++) begin
      if (s_q.carry_v[i] || take[i]) begin
        if (s_q.carry_v[i]) begin
          ridx = {s_q.carry[i*IW+`VFD_SIDE_BIT], s_q.carry[i*IW+`VFD_DST_LSB +: 5]};
          u = s_q.carry[i*IW+`VFD_UNIT_LSB +: 3];
        end else begin
          ridx = {insn[i][`VFD_SIDE_BIT], insn[i][`VFD_DST_LSB +: 5]};
          u = {insn[i][`VFD_SIDE_BIT], insn[i][`VFD_UNIT_LSB +: 2]};
        end
        // unit field picks one of four per side; side bit picks file
        u = s_q.carry_v[i] ? {s_q.carry[i*IW+`VFD_SIDE_BIT], s_q.carry[i*IW+`VFD_UNIT_LSB +: 2]} : u;
        pv[u] = 1'b1;
        // whole word goes to its unit: logic, shift, multiply or data, on side a or b
        pi[u*IW +: IW] = s_q.carry_v[i] ? s_q.carry[i*IW +: IW] : insn[i];
        wr_now[ridx] = 1'b1;
        // cross read: source from the opposite side's file
        if ((s_q.carry_v[i] ? s_q.carry[i*IW+`VFD_XPATH_BIT] : insn[i][`VFD_XPATH_BIT])
            && s_q.wr_last[{~ridx[5], (s_q.carry_v[i] ? s_q.carry[i*IW+`VFD_SRC_LSB +: 5]
                                       : insn[i][`VFD_SRC_LSB +: 5])}]) begin
          hazard = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.req = 1'b0;
    s_d.issue = 1'b0;
    s_d.uv = '0;
    s_d.stall = 1'b0;
    s_d.wr_last = '0;
    case (s_q.st)
      VFD_IDLE: begin
        s_d.req = 1'b1;
        s_d.st = VFD_WAIT;
      end
      VFD_WAIT: begin
        if (fetch_valid) begin
          s_d.fp = fetch_data;
          s_d.pos = '0;
          s_d.pc = s_q.pc + 32'h00000020;
          s_d.st = VFD_RUN;
        end
      end
      VFD_RUN: begin
        // stall only once the whole packet is known, never on a partial packet
        if (found_end && hazard && !s_q.stall) begin
          s_d.stall = 1'b1;
        end else if (!found_end) begin
          // packet runs past this fetch packet; hold slots and refetch
          s_d.carry = s_q.carry;
          for (int i = 0; i < SLOTS; i++) begin
            if (take[i]) begin
              s_d.carry[i*IW +: IW] = insn[i];
              s_d.carry_v[i] = 1'b1;
            end
          end
          s_d.carry_open = 1'b1;
          s_d.req = 1'b1;
          s_d.st = VFD_WAIT;
        end else begin
          s_d.uv = pv;
          s_d.ui = pi;
          s_d.issue = 1'b1;
          s_d.wr_last = wr_now;
          s_d.carry_v = '0;
          s_d.carry_open = 1'b0;
          s_d.pos = end_pos;
          if (end_pos == (PW+1)'(SLOTS)) begin
            s_d.req = 1'b1;
            s_d.st = VFD_WAIT;
          end
        end
      end
      default: s_d.st = VFD_IDLE;
    endcase
    if (srst) begin
      s_d = '0;
      s_d.st = VFD_IDLE;
      s_d.pc = `VFD_RESET_PC;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  assign fetch_req = s_q.req;
  assign fetch_addr = s_q.pc;
  assign unit_valid = s_q.uv;
  assign unit_insn = s_q.ui;
  assign packet_issue = s_q.issue;
  assign xpath_stall = s_q.stall;
endmodule : vfd_dispatch

//--- vfd_asserts.sv
// port checker for vfd_dispatch
// assumes one clock, sync active-high reset
`timescale 1ns/100ps
module vfd_asserts #(parameter int SLOTS = 8, parameter int IW = 32) (
  input wire logic clk, // clock
  input wire logic srst, // reset
  input wire logic fetch_req, // fetch
  input wire logic [31:0] fetch_addr, // addr
  input wire logic fetch_valid, // answer
  input wire logic [SLOTS*IW-1:0] fetch_data, // packet
  input wire logic [SLOTS-1:0] unit_valid, // strobes
  input wire logic [SLOTS*IW-1:0] unit_insn, // insns
  input wire logic packet_issue, // issue
  input wire logic xpath_stall // stall
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  a_issue_units: assert property (packet_issue |-> |unit_valid) else $error("x");
  a_units_issue: assert property (|unit_valid |-> packet_issue) else $error("x");
  a_req_pulse: assert property (fetch_req |=> !fetch_req) else $error("x");
  a_valid_issue: assert property (fetch_valid |-> ##[1:2] packet_issue) else $error("x");
  a_stall_hold: assert property (xpath_stall |-> !packet_issue ##1 packet_issue)
    else $error("x");
  a_stall_nofetch: assert property (xpath_stall |-> !fetch_req) else $error("x");
  a_unit_low: assert property (unit_valid[0] |-> unit_insn[3:1] == 3'h0) else $error("x");
  a_unit_high: assert property (unit_valid[7] |-> unit_insn[227:225] == 3'h7)
    else $error("x");
  c_issue: cover property (packet_issue);
  c_stall: cover property (xpath_stall);
  c_full: cover property (unit_valid == 8'hff);
endmodule : vfd_asserts
bind vfd_dispatch vfd_asserts #(.SLOTS(SLOTS), .IW(IW)) u_chk (.*);

//--- vfd_pmem.sv
// program memory model, lat+1 cycles per fetch
// bench loads mem before reset release
`timescale 1ns/100ps
module vfd_pmem (
  input wire logic clk, // clock
  input wire logic srst, // reset
  input wire logic fetch_req, // fetch
  input wire logic [31:0] fetch_addr, // addr
  input wire logic [1:0] lat, // delay
  output logic fetch_valid, // answer
  output logic [255:0] fetch_data // packet
);
  logic [255:0] mem [16];
  logic [2:0] cnt;
  logic [31:0] a;
  initial begin
    fetch_valid = 1'b0;
    fetch_data = '0;
  end
  always @(posedge clk) begin
    fetch_valid <= 1'b0;
    fetch_data <= ~fetch_data;
    if (srst) cnt <= 3'h0;
    else if (fetch_req) begin
      cnt <= 3'(lat) + 3'h1;
      a <= fetch_addr;
    end else if (cnt == 3'h1) begin
      fetch_valid <= 1'b1;
      fetch_data <= mem[a[8:5]];
      cnt <= 3'h0;
    end else if (cnt != 3'h0) cnt <= cnt - 3'h1;
  end
endmodule : vfd_pmem

//--- vfd_dispatch_tb.sv
// scoreboard bench for vfd_dispatch
// assumes vfd_pmem and bound vfd_asserts
`timescale 1ns/100ps
module vfd_dispatch_tb;
  typedef struct {logic [7:0] v; logic [255:0] i;} vfd_exp_type;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] lat = 2'h0;
  logic fetch_req, fetch_valid, packet_issue, xpath_stall;
  logic [31:0] fetch_addr, w;
  logic [255:0] fetch_data, unit_insn, m;
  logic [7:0] unit_valid;
  vfd_exp_type exp_q[$];
  vfd_exp_type e, g;
  int n_errors = 0;
  int checked = 0;
  int n, k, r, u, j;
  always #5 clk = ~clk;
  vfd_dispatch u_vfd_dispatch (.*);
  vfd_pmem u_vfd_pmem (.*);
  task automatic check(input logic [255:0] seen, input logic [255:0] want);
    checked++;
    if (seen !== want) begin
      n_errors++;
      $display("CHECK FAILED %0t %h %h", $time, seen, want);
    end
  endtask : check
  task automatic report_and_stop;
    if (n_errors == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    lat <= 2'($urandom);
    if (packet_issue === 1'b1 && exp_q.size() > 0) begin
      g = exp_q.pop_front();
      for (int b = 0; b < 256; b++) m[b] = g.v[b/32];
      check(unit_valid, g.v);
      check(unit_insn & m, g.i);
    end
  end
  initial begin
    void'($urandom(85250));
    n = 0;
    while (n < 128) begin
      k = 1 + $urandom % 8;
      if (k > 128 - n) k = 128 - n;
      r = $urandom % 8;
      e.v = '0;
      e.i = '0;
      for (j = 0; j < k; j++) begin
        u = (r + j) % 8;
        w = $urandom;
        w[14:0] = {5'($urandom % 4), 5'($urandom % 4), 1'($urandom % 3 == 0),
          2'(u % 4), 1'(u / 4), 1'(j < k - 1)};
        u_vfd_pmem.mem[n / 8][32 * (n % 8) +: 32] = w;
        e.v[u] = 1'b1;
        e.i[32 * u +: 32] = w;
        n++;
      end
      exp_q.push_back(e);
    end
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    for (j = 0; j < 3000 && exp_q.size() > 0; j++) @(posedge clk);
    if (exp_q.size() > 0) n_errors++;
    report_and_stop();
  end
  initial begin
    #60000;
    n_errors++;
    report_and_stop();
  end
endmodule : vfd_dispatch_tb
